// ==== abgc_pkg.sv ====
// abgc_pkg: offsets, reset values, field positions and carrier types for the bias/gain config slice.
// assumes the serial port front end delivers decoded register accesses with 8-bit addresses.
package abgc_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_PWRDN = 8'h3C;
  localparam logic [7:0] ADDR_CATH = 8'h54;
  localparam logic [7:0] ADDR_GAIN = 8'h55;

  localparam logic [15:0] RST_PWRDN = 16'h3006;
  localparam logic [15:0] RST_CATH = 16'h0020;
  localparam logic [15:0] RST_GAIN = 16'h0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int PD_LSB = 3;
  localparam int PD_W = 6;
  localparam int GLOBAL_BIAS_BIT = 9;
  localparam int OVR_EN_BIT = 7;
  localparam int SLEEP_CATH_LSB = 12;
  localparam int SLOTB_CATH_LSB = 10;
  localparam int SLOTA_CATH_LSB = 8;
  localparam int CH4_GAIN_LSB = 10;
  localparam int CH3_GAIN_LSB = 8;

  // ----------------------------------------
  // codes
  // ----------------------------------------
  localparam logic [1:0] SLOT_CATH_VDD = 2'h0;
  localparam logic [1:0] SLOT_CATH_ANODE = 2'h1;
  localparam logic [1:0] SLOT_CATH_REV250 = 2'h2;
  localparam logic [1:0] SLOT_CATH_ZERO = 2'h3;
  localparam logic [1:0] SLEEP_CATH_VDD = 2'h0;
  localparam logic [1:0] SLEEP_CATH_VREF_IDLE = 2'h1;
  localparam logic [1:0] SLEEP_CATH_FLOAT = 2'h2;
  localparam logic [1:0] SLEEP_CATH_ZERO = 2'h3;
  localparam logic [1:0] GAIN_DEFAULT = 2'h0;

  // cathode drive that the analog bias generator obeys
  typedef enum logic [2:0] {
    ABGC_CATH_VDD,
    ABGC_CATH_VREF,
    ABGC_CATH_FLOAT,
    ABGC_CATH_ZERO,
    ABGC_CATH_ANODE,
    ABGC_CATH_REV250
  } abgc_cath_t;

  // per-amplifier power-down lines
  typedef struct packed {
    logic ch234_integ;
    logic ch234_bpf;
    logic ch234_tia;
    logic ch1_integ;
    logic ch1_bpf;
    logic ch1_tia;
  } abgc_pwrdn_t;

  // operating state of the sequencer
  typedef struct packed {
    logic sleep;
    logic slot_a;
    logic slot_b;
  } abgc_opstate_t;

  // slot B gain selections for channels 3 and 4
  typedef struct packed {
    logic ch4_active;
    logic [1:0] ch4_code;
    logic ch3_active;
    logic [1:0] ch3_code;
  } abgc_gain_t;

endpackage

// ==== abgc_cath_sel.sv ====
// abgc_cath_sel: picks the cathode drive from override, state and stored codes.
// assumes at most one of slot_a, slot_b, sleep is high; slots win over sleep.
`timescale 1ns/10ps
module abgc_cath_sel (
  // configuration
  input wire logic override_en,
  input wire logic global_bias,
  input wire logic [1:0] sleep_code,
  input wire logic [1:0] slot_a_code,
  input wire logic [1:0] slot_b_code,
  // state
  input wire abgc_pkg::abgc_opstate_t opstate,
  // drive
  output abgc_pkg::abgc_cath_t cath
);

  // ----------------------------------------
  // code decoding
  // ----------------------------------------
  function automatic abgc_pkg::abgc_cath_t slot_dec(input logic [1:0] c);
    case (c)
      abgc_pkg::SLOT_CATH_VDD: slot_dec = abgc_pkg::ABGC_CATH_VDD;
      abgc_pkg::SLOT_CATH_ANODE: slot_dec = abgc_pkg::ABGC_CATH_ANODE;
      abgc_pkg::SLOT_CATH_REV250: slot_dec = abgc_pkg::ABGC_CATH_REV250;
      default: slot_dec = abgc_pkg::ABGC_CATH_ZERO;
    endcase
  endfunction

  function automatic abgc_pkg::abgc_cath_t sleep_dec(input logic [1:0] c, input logic asleep);
    case (c)
      abgc_pkg::SLEEP_CATH_VDD: sleep_dec = abgc_pkg::ABGC_CATH_VDD;
      abgc_pkg::SLEEP_CATH_VREF_IDLE: sleep_dec = asleep ? abgc_pkg::ABGC_CATH_VDD : abgc_pkg::ABGC_CATH_VREF;
      abgc_pkg::SLEEP_CATH_FLOAT: sleep_dec = abgc_pkg::ABGC_CATH_FLOAT;
      default: sleep_dec = abgc_pkg::ABGC_CATH_ZERO;
    endcase
  endfunction

  // ----------------------------------------
  // selection
  // ----------------------------------------
  wire abgc_pkg::abgc_cath_t global_cath = global_bias ? abgc_pkg::ABGC_CATH_VDD : abgc_pkg::ABGC_CATH_ANODE; // RQ11
  wire abgc_pkg::abgc_cath_t slot_a_cath = slot_dec(slot_a_code); // RQ7
  wire abgc_pkg::abgc_cath_t slot_b_cath = slot_dec(slot_b_code); // RQ6
  wire abgc_pkg::abgc_cath_t rest_cath = sleep_dec(sleep_code, opstate.sleep); // RQ5
  wire abgc_pkg::abgc_cath_t ovr_cath = opstate.slot_a ? slot_a_cath : (opstate.slot_b ? slot_b_cath : rest_cath);

  assign cath = override_en ? ovr_cath : global_cath; // RQ4

endmodule // abgc_cath_sel

// ==== abgc_regs.sv ====
// abgc_regs: power-down, cathode bias and slot B gain configuration registers.
// assumes the serial port delivers one-cycle write and read strobes with address and data.
// Notes on behaviour
// RQ1: power-down field all zero keeps every analog receive channel on; resets to zero.
// RQ2: bits 3, 4, 5 power down channel 1 TIA, BPF, integrator.
// RQ3: bits 6, 7, 8 power down shared channel 2-4 TIA, BPF, integrator.
// RQ4: override off uses global bias bit; on uses per-state cathode fields.
// RQ5: sleep cathode field applies while asleep; code 1 gives reference idle, supply asleep.
// RQ6: slot B cathode field: supply, anode, 250 mV reverse, 0 V.
// RQ7: slot A cathode field uses the slot B encoding during slot A.
// RQ8: host should program slot cathode fields to code 2.
// RQ9: channel 4 slot B gain acts only while per-channel gain enable is set.
// RQ10: channel 3 slot B gain acts only under the same enable.
// RQ11: global bias bit 0 means cathode equals anode; 1 means 1.8 V.
// RQ12: fields load defaults at reset, keep written values, read back stored values.
`timescale 1ns/10ps
module abgc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // sequencer state
  input wire abgc_pkg::abgc_opstate_t opstate,
  input wire logic slot_b_gain_en,
  // analog controls
  output abgc_pkg::abgc_pwrdn_t pwrdn,
  output abgc_pkg::abgc_cath_t cath,
  output abgc_pkg::abgc_gain_t slot_b_gain
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [15:0] pwrdn_ctrl_r;
  logic [15:0] pwrdn_ctrl_nxt;
  logic [15:0] cath_ctrl_r;
  logic [15:0] cath_ctrl_nxt;
  logic [15:0] gain_ctrl_r;
  logic [15:0] gain_ctrl_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [15:0] rd_mux;
  abgc_pkg::abgc_pwrdn_t pwrdn_r;
  abgc_pkg::abgc_cath_t cath_r;
  abgc_pkg::abgc_gain_t gain_r;

  // ----------------------------------------
  // address decoding
  // ----------------------------------------
  wire hit_pwrdn = (reg_addr == abgc_pkg::ADDR_PWRDN);
  wire hit_cath = (reg_addr == abgc_pkg::ADDR_CATH);
  wire hit_gain = (reg_addr == abgc_pkg::ADDR_GAIN);
  wire wr_pwrdn = reg_wr && hit_pwrdn;
  wire wr_cath = reg_wr && hit_cath;
  wire wr_gain = reg_wr && hit_gain;

  // ----------------------------------------
  // read data selection
  // ----------------------------------------
  // unmapped addresses read as zero
  always_comb begin
    rd_mux = 16'h0000;
    if (hit_pwrdn) begin
      rd_mux = pwrdn_ctrl_r;
    end else if (hit_cath) begin
      rd_mux = cath_ctrl_r;
    end else if (hit_gain) begin
      rd_mux = gain_ctrl_r;
    end
  end

  // ----------------------------------------
  // next values
  // ----------------------------------------
  assign pwrdn_ctrl_nxt = wr_pwrdn ? reg_wdata : pwrdn_ctrl_r; // RQ12
  assign cath_ctrl_nxt = wr_cath ? reg_wdata : cath_ctrl_r; // RQ12
  assign gain_ctrl_nxt = wr_gain ? reg_wdata : gain_ctrl_r; // RQ12
  assign rdata_nxt = reg_rd ? rd_mux : rdata_r; // RQ12
  assign rvalid_nxt = reg_rd; // RQ12

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire [5:0] pd_field = pwrdn_ctrl_r[abgc_pkg::PD_LSB +: abgc_pkg::PD_W];
  wire global_bias = pwrdn_ctrl_r[abgc_pkg::GLOBAL_BIAS_BIT];
  wire override_en = cath_ctrl_r[abgc_pkg::OVR_EN_BIT];
  wire [1:0] sleep_code = cath_ctrl_r[abgc_pkg::SLEEP_CATH_LSB +: 2];
  wire [1:0] slot_b_code = cath_ctrl_r[abgc_pkg::SLOTB_CATH_LSB +: 2];
  wire [1:0] slot_a_code = cath_ctrl_r[abgc_pkg::SLOTA_CATH_LSB +: 2];
  wire [1:0] ch4_code = gain_ctrl_r[abgc_pkg::CH4_GAIN_LSB +: 2];
  wire [1:0] ch3_code = gain_ctrl_r[abgc_pkg::CH3_GAIN_LSB +: 2];

  // ----------------------------------------
  // power-down drive
  // ----------------------------------------
  // all-zero field leaves every amplifier on
  abgc_pkg::abgc_pwrdn_t pwrdn_nxt;
  assign pwrdn_nxt.ch1_tia = pd_field[0]; // RQ2
  assign pwrdn_nxt.ch1_bpf = pd_field[1]; // RQ2
  assign pwrdn_nxt.ch1_integ = pd_field[2]; // RQ2
  assign pwrdn_nxt.ch234_tia = pd_field[3]; // RQ3
  assign pwrdn_nxt.ch234_bpf = pd_field[4]; // RQ3
  assign pwrdn_nxt.ch234_integ = pd_field[5]; // RQ3

  // ----------------------------------------
  // cathode bias
  // ----------------------------------------
  abgc_pkg::abgc_cath_t cath_nxt;

  abgc_cath_sel u_cath_sel (
    .override_en(override_en),
    .global_bias(global_bias),
    .sleep_code(sleep_code),
    .slot_a_code(slot_a_code),
    .slot_b_code(slot_b_code),
    .opstate(opstate),
    .cath(cath_nxt)
  );

  // ----------------------------------------
  // slot B gains
  // ----------------------------------------
  // disabled: gain falls back to the default code
  abgc_pkg::abgc_gain_t gain_nxt;
  assign gain_nxt.ch4_active = slot_b_gain_en; // RQ9
  assign gain_nxt.ch4_code = slot_b_gain_en ? ch4_code : abgc_pkg::GAIN_DEFAULT; // RQ9
  assign gain_nxt.ch3_active = slot_b_gain_en; // RQ10
  assign gain_nxt.ch3_code = slot_b_gain_en ? ch3_code : abgc_pkg::GAIN_DEFAULT; // RQ10

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwrdn_ctrl_r <= abgc_pkg::RST_PWRDN; // RQ1
    end else begin
      pwrdn_ctrl_r <= pwrdn_ctrl_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cath_ctrl_r <= abgc_pkg::RST_CATH;
    end else begin
      cath_ctrl_r <= cath_ctrl_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_ctrl_r <= abgc_pkg::RST_GAIN;
    end else begin
      gain_ctrl_r <= gain_ctrl_nxt;
    end
  end

  // ----------------------------------------
  // read response registers
  // ----------------------------------------
  // read data holds until the next read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  // ----------------------------------------
  // analog control registers
  // ----------------------------------------
  // outputs lag the control registers by one cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwrdn_r <= '0; // RQ1
    end else begin
      pwrdn_r <= pwrdn_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cath_r <= abgc_pkg::ABGC_CATH_ANODE;
    end else begin
      cath_r <= cath_nxt;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gain_r <= '0;
    end else begin
      gain_r <= gain_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign pwrdn = pwrdn_r;
  assign cath = cath_r;
  assign slot_b_gain = gain_r;

endmodule // abgc_regs

// ==== abgc_regs_assertions.sv ====
// abgc_regs_assertions: port-level checks of the bias/gain config slice.
// assumes abgc_regs ports; one clock, async high reset.
`timescale 1ns/10ps
module abgc_regs_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // state and analog controls
  input wire abgc_pkg::abgc_opstate_t opstate,
  input wire logic slot_b_gain_en,
  input wire abgc_pkg::abgc_pwrdn_t pwrdn,
  input wire abgc_pkg::abgc_cath_t cath,
  input wire abgc_pkg::abgc_gain_t slot_b_gain
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire is_pd = reg_addr == abgc_pkg::ADDR_PWRDN;
  wire mapped = is_pd || reg_addr == abgc_pkg::ADDR_CATH || reg_addr == abgc_pkg::ADDR_GAIN;

  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("stray rvalid");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_write_readback: assert property ((reg_wr && mapped && !reg_rd) ##1 (reg_rd && !reg_wr && $stable(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
  a_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
  a_pwrdn_write: assert property (reg_wr && is_pd |-> ##2 pwrdn == $past(reg_wdata[8:3], 2))
    else $error("pwrdn not from write");
  a_pwrdn_cause: assert property ($changed(pwrdn) |-> $past(reg_wr, 2) && $past(is_pd, 2))
    else $error("pwrdn changed alone");
  a_cath_cause: assert property ($changed(cath) |-> $past(reg_wr, 2) || $past(opstate) != $past(opstate, 2))
    else $error("cath changed alone");
  a_gain_off: assert property (!slot_b_gain_en |=> slot_b_gain == 6'h00) else $error("gain not off");
  a_gain_on: assert property (slot_b_gain_en |=> slot_b_gain.ch4_active && slot_b_gain.ch3_active)
    else $error("gain not active");

  c_read: cover property (reg_rvalid && reg_rdata != 16'h0000);
  c_vref: cover property (cath == abgc_pkg::ABGC_CATH_VREF);
  c_gain: cover property (slot_b_gain.ch4_active);
endmodule // abgc_regs_chk

bind abgc_regs abgc_regs_chk i_chk (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .opstate(opstate), .slot_b_gain_en(slot_b_gain_en), .pwrdn(pwrdn), .cath(cath), .slot_b_gain(slot_b_gain));

// ==== abgc_regs_test.sv ====
// abgc_regs_test: register and analog control tests of the config slice.
// assumes abgc_pkg and abgc_regs compiled first.
`timescale 1ns/10ps
module abgc_regs_test;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, slot_b_gain_en = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic reg_rvalid;
  logic [1:0] sc, bc, ac;
  logic [2:0] sts [5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3};
  abgc_pkg::abgc_opstate_t opstate = '0;
  abgc_pkg::abgc_pwrdn_t pwrdn;
  abgc_pkg::abgc_cath_t cath;
  abgc_pkg::abgc_gain_t slot_b_gain;
  int fails = 0, checked = 0, cycles = 0;

  abgc_regs i_dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .opstate(opstate),
    .slot_b_gain_en(slot_b_gain_en), .pwrdn(pwrdn), .cath(cath), .slot_b_gain(slot_b_gain));

  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cycles == 3000) begin
    fails++;
    finish_test();
  end

  task automatic finish_test;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [16:0] s, input logic [16:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({reg_rvalid, reg_rdata}, {1'b1, e});
  endtask
  // expected drive for the code that applies in state s
  function automatic abgc_pkg::abgc_cath_t exp_cath(input logic [1:0] c, input logic [2:0] s);
    if (c == 2'h3) return abgc_pkg::ABGC_CATH_ZERO;
    if (c == 2'h0) return abgc_pkg::ABGC_CATH_VDD;
    if (s[1:0] != 2'h0) return c == 2'h1 ? abgc_pkg::ABGC_CATH_ANODE : abgc_pkg::ABGC_CATH_REV250;
    if (c == 2'h2) return abgc_pkg::ABGC_CATH_FLOAT;
    return s[2] ? abgc_pkg::ABGC_CATH_VDD : abgc_pkg::ABGC_CATH_VREF;
  endfunction

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    settle();
    chk(pwrdn, 17'h0);
    chk(cath, abgc_pkg::ABGC_CATH_ANODE);
    rd(abgc_pkg::ADDR_PWRDN, 16'h3006);
    rd(abgc_pkg::ADDR_CATH, 16'h0020);
    rd(abgc_pkg::ADDR_GAIN, 16'h0000);
    wr(8'h3D, 16'hFFFF);
    rd(8'h3D, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      wr(abgc_pkg::ADDR_PWRDN, 16'h3006 | (16'h0008 << i));
      settle();
      chk(pwrdn, 6'h01 << i);
      rd(abgc_pkg::ADDR_PWRDN, 16'h3006 | (16'h0008 << i));
    end
    wr(abgc_pkg::ADDR_PWRDN, 16'h3206);
    settle();
    chk({pwrdn, cath}, {6'h00, abgc_pkg::ABGC_CATH_VDD});
    for (int c = 0; c < 4; c++) begin
      sc = 2'(c);
      bc = 2'(c + 1);
      ac = 2'(c + 2);
      wr(abgc_pkg::ADDR_CATH, {2'h0, sc, bc, ac, 1'b1, 7'h20});
      for (int s = 0; s < 5; s++) begin
        @(posedge clk);
        opstate <= sts[s];
        settle();
        chk(cath, exp_cath(sts[s][1] ? ac : sts[s][0] ? bc : sc, sts[s]));
      end
    end
    wr(abgc_pkg::ADDR_CATH, 16'h0020);
    settle();
    chk(cath, abgc_pkg::ABGC_CATH_VDD);
    for (int c = 0; c < 4; c++) begin
      wr(abgc_pkg::ADDR_GAIN, {4'h0, 2'(c), 2'(3 - c), 8'h00});
      for (int e = 0; e < 2; e++) begin
        @(posedge clk);
        slot_b_gain_en <= e[0];
        settle();
        chk(slot_b_gain, e[0] ? {1'b1, 2'(c), 1'b1, 2'(3 - c)} : 6'h00);
      end
    end
    // back-to-back write then read, host-recommended slot codes
    @(posedge clk);
    opstate <= 3'h1;
    reg_wr <= 1'b1;
    reg_addr <= abgc_pkg::ADDR_CATH;
    reg_wdata <= 16'h0A80;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk({reg_rvalid, reg_rdata}, {1'b1, 16'h0A80});
    settle();
    chk(cath, abgc_pkg::ABGC_CATH_REV250);
    @(posedge clk);
    opstate <= 3'h2;
    settle();
    chk(cath, abgc_pkg::ABGC_CATH_REV250);
    finish_test();
  end
endmodule // abgc_regs_test
